// >>> logic/fault_diag_pkg.sv
package fault_diag_pkg;

  localparam int          NUM_CH        = 8;
  localparam int          CLK_MHZ       = 200;
  localparam int          BLANK_US      = 4000;
  localparam int          BLANK_LONG_US = 8000;
  localparam int          AVG_US        = 4000;
  localparam int          OC_FILT_NS    = 54000;
  localparam int          BLANK_CYC     = BLANK_US * CLK_MHZ;
  localparam int          BLANK_L_CYC   = BLANK_LONG_US * CLK_MHZ;
  localparam int          AVG_CYC       = AVG_US * CLK_MHZ;
  localparam int          OC_FILT_CYC   = (OC_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int          TMR_W         = 24;
  localparam logic [1:0]  THR_FORCED    = 2'h0;

  // Summary bit positions.
  localparam int          SUM_OVL       = 0;
  localparam int          SUM_CL        = 1;
  localparam int          SUM_OWON      = 2;
  localparam int          SUM_OWOFF     = 3;
  localparam int          SUM_SHT       = 4;
  localparam int          SUM_SUPPLY    = 5;
  localparam int          SUM_WARN      = 6;
  localparam int          SUM_COM       = 7;

  typedef enum logic [1:0] {
    REG_OVL,
    REG_CL,
    REG_OWON,
    REG_OWOFF
  } unused_sel_t;

  typedef struct packed {
    logic [7:0] overload;
    logic [7:0] current_limit;
    logic [7:0] open_wire_on;
    logic [7:0] open_wire_off;
    logic [7:0] short_supply;
  } chan_vec_t;

  typedef struct packed {
    logic chip_thermal_shutdown_flag;
    logic internal_supply_low_flag;
    logic aux_supply_lockout_flag;
    logic supply_lockout_flag;
    logic supply_not_good_flag;
    logic supply_warning;
    logic watchdog_timeout;
    logic sync_stuck_low;
    logic spi_frame_error;
  } global_raw_t;

  typedef struct packed {
    logic summary;
    logic ovl;
    logic cl;
    logic owon;
    logic owoff;
    logic sht;
    logic global_err;
  } read_strobe_t;

  typedef struct packed {
    logic overload_mask;
    logic current_limit_mask;
    logic open_wire_on_mask;
    logic open_wire_off_mask;
    logic short_supply_mask;
    logic supply_error_mask;
    logic supply_warning_mask;
    logic communication_error_mask;
  } mask_t;

endpackage

// >>> logic/chan_timer.sv
`timescale 1ns/1ps
module chan_timer
  import fault_diag_pkg::*;
#(
  parameter int BLANK = BLANK_CYC,
  parameter int BLANK_L = BLANK_L_CYC,
  parameter int AVG = AVG_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_switch,
  input  wire logic i_long_blank,
  input  wire logic i_ow_on_raw,
  input  wire logic i_ow_off_raw,
  input  wire logic i_sht_raw,
  output logic      o_update,
  output logic      o_ow_on,
  output logic      o_ow_off,
  output logic      o_sht,
  output logic      o_toggle
);

  typedef enum logic [1:0] {ST_BLANK, ST_AVG, ST_RUN} phase_t;

  phase_t           phase_q;
  logic             sw_q;
  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] on_q;
  logic [TMR_W-1:0] off_q;
  logic [TMR_W-1:0] sht_q;
  logic             toggle;
  logic [TMR_W-1:0] blank_end;

  assign toggle    = i_switch != sw_q;
  assign o_toggle  = toggle;
  assign blank_end = i_long_blank ? TMR_W'(BLANK_L - 1) : TMR_W'(BLANK - 1);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sw_q <= 1'b0;
    end else begin
      sw_q <= i_switch;
    end
  end

  // ----------------------------------------------------------------------
  // Blanking then averaging after every switching instant.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_q  <= ST_BLANK;
      cnt_q    <= '0;
      on_q     <= '0;
      off_q    <= '0;
      sht_q    <= '0;
      o_update <= 1'b0;
      o_ow_on  <= 1'b0;
      o_ow_off <= 1'b0;
      o_sht    <= 1'b0;
    end else begin
      o_update <= 1'b0;
      if (toggle) begin
        // Previous-state results are stale once the switch moves.
        phase_q  <= ST_BLANK;
        cnt_q    <= '0;
        on_q     <= '0;
        off_q    <= '0;
        sht_q    <= '0;
        o_ow_on  <= 1'b0;
        o_ow_off <= 1'b0;
        o_sht    <= 1'b0;
      end else begin
        case (phase_q)
          ST_BLANK: begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q >= blank_end) begin
              phase_q <= ST_AVG;
              cnt_q   <= '0;
            end
          end
          ST_AVG, ST_RUN: begin
            cnt_q <= cnt_q + 1'b1;
            on_q  <= on_q + TMR_W'(i_ow_on_raw);
            off_q <= off_q + TMR_W'(i_ow_off_raw);
            sht_q <= sht_q + TMR_W'(i_sht_raw);
            if (cnt_q == TMR_W'(AVG - 1)) begin
              // Majority over the window; a new window starts at once.
              o_ow_on  <= on_q >= TMR_W'(AVG / 2);
              o_ow_off <= off_q >= TMR_W'(AVG / 2);
              o_sht    <= sht_q >= TMR_W'(AVG / 2);
              o_update <= 1'b1;
              phase_q  <= ST_RUN;
              cnt_q    <= '0;
              on_q     <= '0;
              off_q    <= '0;
              sht_q    <= '0;
            end
          end
          default: phase_q <= ST_BLANK;
        endcase
      end
    end
  end

endmodule

// >>> logic/output_fault_diagnostics.sv
`timescale 1ns/1ps
module output_fault_diagnostics
  import fault_diag_pkg::*;
#(
  parameter int BLANK = BLANK_CYC,
  parameter int BLANK_L = BLANK_L_CYC,
  parameter int AVG = AVG_CYC,
  parameter int OC_FILT = OC_FILT_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [NUM_CH-1:0] i_switch_on,
  input  wire logic [NUM_CH-1:0] i_lamp_detect,
  input  wire logic [NUM_CH-1:0] i_overload_raw,
  input  wire logic [NUM_CH-1:0] i_overcurrent_raw,
  input  wire logic [NUM_CH-1:0] i_below_current_threshold,
  input  wire logic [NUM_CH-1:0] i_above_open_voltage,
  input  wire logic [NUM_CH-1:0] i_above_short_threshold,
  input  wire logic [NUM_CH-1:0] i_open_wire_on_enable,
  input  wire logic [NUM_CH-1:0] i_open_wire_off_enable,
  input  wire logic [NUM_CH-1:0] i_short_detect_enable,
  input  wire logic              i_long_blank,
  input  wire logic              i_fault_latch_enable,
  input  wire logic              i_short_threshold_select_low,
  input  wire logic              i_short_threshold_select_high,
  input  wire logic              i_supply_good,
  input  wire global_raw_t       i_global_raw,
  input  wire logic [1:0]        i_watchdog_timeout_field,
  input  wire logic              i_sync_watchdog_enable,
  input  wire logic              i_address_low_watchdog_pin,
  input  wire logic              i_address_high_sync_watchdog_pin,
  input  wire logic              i_crc_enable_pin,
  input  wire logic              i_chain_select_pin,
  input  wire mask_t             i_mask,
  input  wire read_strobe_t      i_read,
  input  wire logic              i_spi_cycle_done,
  output chan_vec_t              o_chan_faults,
  output logic [7:0]             o_summary,
  output logic [8:0]             o_global_error_register,
  output logic                   o_short_supply_global_fault,
  output logic [NUM_CH-1:0]      o_open_load_pullup_source,
  output logic [1:0]             o_short_threshold,
  output logic                   o_outputs_off,
  output logic                   o_fault_n_out,
  output logic                   o_fault_n_oe
);

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  logic [3:0] pin_meta_q;
  logic [3:0] pin_q;
  logic       daisy;
  logic       wd_pin;
  logic       swd_pin;
  logic       crc_pin;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_q <= '0;
      pin_q      <= '0;
    end else begin
      pin_meta_q <= {i_chain_select_pin, i_address_low_watchdog_pin,
                     i_address_high_sync_watchdog_pin, i_crc_enable_pin};
      pin_q      <= pin_meta_q;
    end
  end

  assign daisy   = pin_q[3];
  assign wd_pin  = pin_q[2];
  assign swd_pin = pin_q[1];
  assign crc_pin = pin_q[0];

  // ----------------------------------------------------------------------
  // Short threshold and pull-up sources.
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_short_threshold         <= THR_FORCED;
      o_open_load_pullup_source <= '0;
    end else begin
      o_short_threshold <= i_supply_good ?
          {i_short_threshold_select_high, i_short_threshold_select_low} : THR_FORCED;
      o_open_load_pullup_source <= i_open_wire_off_enable & ~i_switch_on;
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel raw detection.
  // ----------------------------------------------------------------------
  chan_vec_t        det;
  logic [NUM_CH-1:0] upd;
  logic [NUM_CH-1:0] ow_on_av;
  logic [NUM_CH-1:0] ow_off_av;
  logic [NUM_CH-1:0] sht_av;
  logic [NUM_CH-1:0] ovl_filt_q;
  logic [NUM_CH-1:0] cl_filt_q;
  logic [15:0]       ovl_cnt_q [NUM_CH];
  logic [15:0]       cl_cnt_q  [NUM_CH];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    chan_timer #(
      .BLANK   (BLANK),
      .BLANK_L (BLANK_L),
      .AVG     (AVG)
    ) u_timer (
      .i_clk        (i_clk),
      .i_rst        (i_rst),
      .i_switch     (i_switch_on[c]),
      .i_long_blank (i_long_blank),
      .i_ow_on_raw  (i_switch_on[c] & i_below_current_threshold[c]),
      .i_ow_off_raw (~i_switch_on[c] & i_above_open_voltage[c]
                     & ~i_above_short_threshold[c]),
      .i_sht_raw    (~i_switch_on[c] & i_above_short_threshold[c]),
      .o_update     (upd[c]),
      .o_ow_on      (ow_on_av[c]),
      .o_ow_off     (ow_off_av[c]),
      .o_sht        (sht_av[c]),
      .o_toggle     ()
    );

    // Filter without blanking; the lamp interval resets the count.
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        ovl_cnt_q[c]  <= '0;
        cl_cnt_q[c]   <= '0;
        ovl_filt_q[c] <= 1'b0;
        cl_filt_q[c]  <= 1'b0;
      end else begin
        if (!i_overload_raw[c] || i_lamp_detect[c]) begin
          ovl_cnt_q[c]  <= '0;
          ovl_filt_q[c] <= 1'b0;
        end else if (ovl_cnt_q[c] == 16'(OC_FILT - 1)) begin
          ovl_filt_q[c] <= 1'b1;
        end else begin
          ovl_cnt_q[c] <= ovl_cnt_q[c] + 16'h0001;
        end
        if (!i_overcurrent_raw[c] || i_lamp_detect[c]) begin
          cl_cnt_q[c]  <= '0;
          cl_filt_q[c] <= 1'b0;
        end else if (cl_cnt_q[c] == 16'(OC_FILT - 1)) begin
          cl_filt_q[c] <= 1'b1;
        end else begin
          cl_cnt_q[c] <= cl_cnt_q[c] + 16'h0001;
        end
      end
    end
  end

  assign det.overload      = ovl_filt_q & ~i_lamp_detect;
  assign det.current_limit = cl_filt_q & ~i_lamp_detect;
  assign det.open_wire_on  = ow_on_av & i_open_wire_on_enable;
  assign det.open_wire_off = ow_off_av & i_open_wire_off_enable;
  assign det.short_supply  = sht_av & i_short_detect_enable;

  // ----------------------------------------------------------------------
  // Per-channel register bits, latched or real-time.
  // ----------------------------------------------------------------------
  chan_vec_t   flags_q;
  logic        latched;
  logic [4:0]  rd_reg;

  assign latched = i_fault_latch_enable;
  // In daisy mode every completed SPI cycle acts as a read of all registers.
  assign rd_reg  = daisy ? {5{i_spi_cycle_done}} :
                   {i_read.ovl, i_read.cl, i_read.owon, i_read.owoff, i_read.sht};

  function automatic logic [NUM_CH-1:0] next_bits(
    input logic [NUM_CH-1:0] cur,
    input logic [NUM_CH-1:0] now,
    input logic              rd
  );
    if (!latched) begin
      next_bits = now;
    end else begin
      // Set wins over the read clear; a live cause keeps the bit.
      next_bits = now | (rd ? '0 : cur);
    end
  endfunction

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= '0;
    end else begin
      flags_q.overload      <= next_bits(flags_q.overload, det.overload, rd_reg[4]);
      flags_q.current_limit <= next_bits(flags_q.current_limit, det.current_limit,
                                         rd_reg[3]);
      flags_q.open_wire_on  <= next_bits(flags_q.open_wire_on, det.open_wire_on,
                                         rd_reg[2]);
      flags_q.open_wire_off <= next_bits(flags_q.open_wire_off, det.open_wire_off,
                                         rd_reg[1]);
      flags_q.short_supply  <= next_bits(flags_q.short_supply, det.short_supply,
                                         rd_reg[0]);
    end
  end

  assign o_chan_faults = flags_q;

  // ----------------------------------------------------------------------
  // Global errors.
  // ----------------------------------------------------------------------
  logic [8:0] gnow;
  logic [8:0] glob_q;
  logic       wd_en;
  logic       sync_en;

  assign wd_en   = daisy ? wd_pin : (i_watchdog_timeout_field != 2'h0);
  assign sync_en = daisy ? swd_pin : i_sync_watchdog_enable;
  assign gnow = {i_global_raw.chip_thermal_shutdown_flag,
                 i_global_raw.internal_supply_low_flag,
                 i_global_raw.aux_supply_lockout_flag,
                 i_global_raw.supply_lockout_flag,
                 i_global_raw.supply_not_good_flag,
                 i_global_raw.supply_warning,
                 i_global_raw.watchdog_timeout & wd_en,
                 i_global_raw.sync_stuck_low & sync_en,
                 i_global_raw.spi_frame_error & crc_pin};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      glob_q <= '0;
    end else if (latched || !daisy) begin
      glob_q <= gnow | ((rd_reg != '0 && daisy) || i_read.global_err ? '0 : glob_q);
    end else begin
      glob_q <= gnow;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_global_error_register     <= '0;
      o_short_supply_global_fault <= 1'b0;
      o_outputs_off               <= 1'b0;
    end else begin
      o_global_error_register     <= glob_q;
      o_short_supply_global_fault <= |flags_q.short_supply;
      o_outputs_off               <= i_global_raw.supply_lockout_flag;
    end
  end

  // ----------------------------------------------------------------------
  // Summary and fault pin.
  // ----------------------------------------------------------------------
  logic [7:0] sum;
  logic [7:0] mvec;
  logic [7:0] sum_q;
  logic       pending_q;

  always_comb begin
    sum            = '0;
    sum[SUM_OVL]   = |flags_q.overload;
    sum[SUM_CL]    = |flags_q.current_limit;
    sum[SUM_OWON]  = |flags_q.open_wire_on;
    sum[SUM_OWOFF] = |flags_q.open_wire_off;
    sum[SUM_SHT]   = |flags_q.short_supply;
    sum[SUM_SUPPLY] = glob_q[5] | glob_q[6] | glob_q[7] | glob_q[8];
    sum[SUM_WARN]  = glob_q[4] | glob_q[3];
    sum[SUM_COM]   = |glob_q[2:0];
  end

  assign mvec = {i_mask.communication_error_mask, i_mask.supply_warning_mask,
                 i_mask.supply_error_mask, i_mask.short_supply_mask,
                 i_mask.open_wire_off_mask, i_mask.open_wire_on_mask,
                 i_mask.current_limit_mask, i_mask.overload_mask};

  // A new unmasked fault wins over a summary read in the same cycle.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pending_q <= 1'b0;
    end else if (!latched || daisy) begin
      pending_q <= 1'b0;
    end else if ((sum & ~mvec & ~sum_q) != '0) begin
      pending_q <= 1'b1;
    end else if (i_read.summary) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sum_q         <= '0;
      o_summary     <= '0;
      o_fault_n_out <= 1'b0;
      o_fault_n_oe  <= 1'b0;
    end else begin
      sum_q         <= sum;
      o_summary     <= sum;
      // Open drain: output value is always low, only the enable moves.
      o_fault_n_out <= 1'b0;
      o_fault_n_oe  <= ((sum & ~mvec) != '0) || pending_q;
    end
  end

  property p_pin_follows;
    @(posedge i_clk) disable iff (i_rst)
      ((sum & ~mvec) != '0) |=> o_fault_n_oe;
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("fault pin not driven");

  property p_lockout_off;
    @(posedge i_clk) disable iff (i_rst)
      i_global_raw.supply_lockout_flag |=> o_outputs_off;
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("outputs not off");

  property p_summary_or;
    @(posedge i_clk) disable iff (i_rst)
      1'b1 |=> o_summary[SUM_OVL] == ($past(flags_q.overload) != '0);
  endproperty
  a_summary_or: assert property (p_summary_or) else $error("summary not OR");

  property p_realtime;
    @(posedge i_clk) disable iff (i_rst)
      !latched |=> flags_q.overload == $past(det.overload);
  endproperty
  a_realtime: assert property (p_realtime) else $error("flag not real-time");

  property p_latch_hold;
    @(posedge i_clk) disable iff (i_rst)
      (latched && flags_q.overload[0] && !rd_reg[4]) |=> flags_q.overload[0];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched bit lost");

  property p_lamp;
    @(posedge i_clk) disable iff (i_rst)
      (i_lamp_detect[0] && !flags_q.overload[0] && !flags_q.current_limit[0])
        |=> !flags_q.overload[0] && !flags_q.current_limit[0];
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp interval set bit");

  property p_sht_off_only;
    @(posedge i_clk) disable iff (i_rst)
      i_switch_on[0] |-> ##1 !(upd[0] && sht_av[0]) || !$past(i_switch_on[0]);
  endproperty
  a_sht_off_only: assert property (p_sht_off_only) else $error("short while on");

  property p_threshold;
    @(posedge i_clk) disable iff (i_rst)
      !i_supply_good |=> o_short_threshold == THR_FORCED;
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold not forced");

endmodule

// >>> bench/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model
  import fault_diag_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire read_strobe_t i_req,
  input  wire logic         i_go,
  output read_strobe_t      o_read,
  output logic              o_cycle_done
);
  // ----------------------------------------
  // Host read cycles
  // ----------------------------------------
  // A frame completes one cycle after the request, so strobes never overlap a request change.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_read       <= '0;
      o_cycle_done <= 1'b0;
    end else begin
      o_read       <= i_go ? i_req : '0;
      o_cycle_done <= i_go;
    end
  end
endmodule

// >>> bench/output_fault_diagnostics_tb.sv
`timescale 1ns/1ps
module output_fault_diagnostics_tb
  import fault_diag_pkg::*;
;
  localparam int BL = 20;
  localparam int AV = 20;
  localparam int OCF = 5;
  logic i_clk, i_rst, lb, latch, thl, thh, good, swe, a0, a1, crc, chain, go;
  logic [7:0] sw, lamp, ovl, oc, below, aov, ash, owon, owoff, shen, summ, pull;
  logic [1:0] wdt, thr;
  logic [8:0] greg;
  logic gsht, off, f_out, f_oe;
  global_raw_t graw;
  mask_t mask;
  read_strobe_t req, rds;
  logic sdone;
  chan_vec_t flags;
  int failures, checks;
  // The pin is open-drain with a pull-up, so it is high unless the block drives it.
  wire fault_n = f_oe ? f_out : 1'b1;

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  output_fault_diagnostics #(.BLANK(BL), .BLANK_L(2*BL), .AVG(AV), .OC_FILT(OCF))
  u_output_fault_diagnostics (.i_clk(i_clk), .i_rst(i_rst), .i_switch_on(sw),
    .i_lamp_detect(lamp), .i_overload_raw(ovl), .i_overcurrent_raw(oc),
    .i_below_current_threshold(below), .i_above_open_voltage(aov),
    .i_above_short_threshold(ash), .i_open_wire_on_enable(owon),
    .i_open_wire_off_enable(owoff), .i_short_detect_enable(shen), .i_long_blank(lb),
    .i_fault_latch_enable(latch), .i_short_threshold_select_low(thl),
    .i_short_threshold_select_high(thh), .i_supply_good(good), .i_global_raw(graw),
    .i_watchdog_timeout_field(wdt), .i_sync_watchdog_enable(swe),
    .i_address_low_watchdog_pin(a0), .i_address_high_sync_watchdog_pin(a1),
    .i_crc_enable_pin(crc), .i_chain_select_pin(chain), .i_mask(mask), .i_read(rds),
    .i_spi_cycle_done(sdone), .o_chan_faults(flags), .o_summary(summ),
    .o_global_error_register(greg), .o_short_supply_global_fault(gsht),
    .o_open_load_pullup_source(pull), .o_short_threshold(thr), .o_outputs_off(off),
    .o_fault_n_out(f_out), .o_fault_n_oe(f_oe));
  spi_host_model u_spi_host_model (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_go(go),
    .o_read(rds), .o_cycle_done(sdone));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task wait_pin(input logic v);
    int n;
    n = 0;
    while (fault_n !== v && n < 50) begin
      tick(1);
      n++;
    end
    chk(fault_n, v);
    if (n == 50) tally_and_finish();
  endtask
  task rd(input read_strobe_t r);
    req = r;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(4);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_overload;
    ovl = 8'h01;
    tick(2);
    chk(flags.overload, 8'h00);
    tick(OCF + 3);
    chk(flags.overload, 8'h01);
    chk(summ[SUM_OVL], 1'b1);
    wait_pin(1'b0);
    mask.overload_mask = 1'b1;
    tick(3);
    chk(fault_n, 1'b1);
    mask.overload_mask = 1'b0;
    ovl = 8'h00;
    tick(OCF + 4);
    chk(flags.overload, 8'h00);
    wait_pin(1'b1);
    $display("test overload done");
  endtask
  task t_lamp;
    lamp = 8'h01;
    oc = 8'h01;
    tick(OCF + 4);
    chk(flags.current_limit, 8'h00);
    lamp = 8'h00;
    tick(OCF + 4);
    chk(flags.current_limit, 8'h01);
    oc = 8'h00;
    tick(OCF + 4);
    chk(flags.current_limit, 8'h00);
    $display("test lamp done");
  endtask
  task t_latch;
    latch = 1'b1;
    ovl = 8'h01;
    tick(OCF + 4);
    ovl = 8'h00;
    tick(OCF + 4);
    chk(flags.overload, 8'h01);
    rd(7'h40);
    chk(fault_n, 1'b0);
    rd(7'h20);
    chk(flags.overload, 8'h00);
    wait_pin(1'b1);
    ovl = 8'h01;
    tick(OCF + 4);
    ovl = 8'h00;
    tick(OCF + 4);
    rd(7'h20);
    chk(flags.overload, 8'h00);
    chk(fault_n, 1'b0);
    rd(7'h40);
    wait_pin(1'b1);
    latch = 1'b0;
    $display("test latch done");
  endtask
  task t_diag;
    {owon, owoff, shen} = {8'h02, 8'h01, 8'h04};
    sw = 8'h0f;
    tick(1);
    sw = 8'h02;
    tick(BL - 2);
    chk(flags.open_wire_off | flags.short_supply, 8'h00);
    tick(AV + 8);
    chk(flags.open_wire_off, 8'h01);
    chk(flags.short_supply, 8'h04);
    chk(flags.open_wire_on, 8'h02);
    chk(pull[0], 1'b1);
    chk(gsht, 1'b1);
    chk(summ[SUM_OWOFF], 1'b1);
    sw = 8'h03;
    tick(3);
    chk(flags.open_wire_off[0], 1'b0);
    {owon, owoff, shen} = '0;
    tick(3);
    wait_pin(1'b1);
    $display("test diag done");
  endtask
  task t_global;
    graw.supply_lockout_flag = 1'b1;
    tick(4);
    chk(off, 1'b1);
    chk(greg, 9'h020);
    mask.supply_error_mask = 1'b1;
    tick(3);
    chk(fault_n, 1'b1);
    graw = '0;
    crc = 1'b1;
    graw.spi_frame_error = 1'b1;
    tick(4);
    chk(summ[SUM_COM], 1'b1);
    crc = 1'b0;
    tick(3);
    rd(7'h01);
    chk(summ[SUM_COM], 1'b0);
    wdt = 2'h1;
    graw.watchdog_timeout = 1'b1;
    tick(4);
    chk(summ[SUM_COM], 1'b1);
    mask.communication_error_mask = 1'b1;
    tick(3);
    chk(fault_n, 1'b1);
    graw = '0;
    mask = '0;
    rd(7'h01);
    good = 1'b0;
    thl = 1'b1;
    thh = 1'b1;
    tick(3);
    chk(thr, THR_FORCED);
    good = 1'b1;
    tick(3);
    chk(thr, 2'h3);
    $display("test global done");
  endtask
  task t_daisy;
    chain = 1'b1;
    latch = 1'b1;
    tick(3);
    ovl = 8'h08;
    tick(OCF + 4);
    ovl = 8'h00;
    tick(OCF + 4);
    chk(flags.overload, 8'h08);
    chk(fault_n, 1'b0);
    rd(7'h00);
    chk(flags.overload, 8'h00);
    wait_pin(1'b1);
    chain = 1'b0;
    latch = 1'b0;
    tick(3);
    $display("test daisy done");
  endtask

  initial begin
    {lb, latch, thl, thh, swe, a0, a1, crc, chain, go} = '0;
    {sw, lamp, ovl, oc, wdt} = '0;
    good = 1'b1;
    below = 8'h02;
    aov = 8'h01;
    ash = 8'h04;
    {owon, owoff, shen} = '0;
    graw = '0;
    mask = '0;
    req = '0;
    failures = 0;
    checks = 0;
    i_rst = 1'b1;
    repeat (3) @(posedge i_clk);
    #1 i_rst = 1'b0;
    tick(3);
    t_overload();
    t_lamp();
    t_latch();
    t_diag();
    t_global();
    t_daisy();
    tally_and_finish();
  end
endmodule
